// ==== hdl/usd_pkg.sv ====
package usd_pkg;

  // ==========================================================
  // Register byte addresses.
  localparam logic [7:0] ADDR_BAUD = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_CTL3 = 8'h0C;
  localparam logic [7:0] ADDR_DATA = 8'h10;

  // ==========================================================
  // Field positions of uart_control_three.
  localparam int unsigned C3_RX_NINTH = 7;
  localparam int unsigned C3_TX_NINTH = 6;
  localparam int unsigned C3_PIN_DIR = 5;
  localparam int unsigned C3_TX_INV = 4;
  localparam int unsigned C3_OVR_IE = 3;
  localparam int unsigned C3_NOISE_IE = 2;
  localparam int unsigned C3_FRAME_IE = 1;
  localparam int unsigned C3_PAR_IE = 0;

  // ==========================================================
  // Field positions of the mode control register.
  localparam int unsigned CT_RX_EN = 0;
  localparam int unsigned CT_TX_EN = 1;
  localparam int unsigned CT_NINE_BIT = 2;
  localparam int unsigned CT_PAR_EN = 3;
  localparam int unsigned CT_PAR_ODD = 4;
  localparam int unsigned CT_LOOP_SEL = 5;
  localparam int unsigned CT_RX_SRC_SEL = 6;

  // ==========================================================
  // Field positions of uart_status_one and of the flag vector.
  localparam int unsigned ST_TX_ROOM = 7;
  localparam int unsigned ST_TX_DONE = 6;
  localparam int unsigned FL_RX_FULL = 4;
  localparam int unsigned FL_OVERRUN = 3;
  localparam int unsigned FL_NOISE = 2;
  localparam int unsigned FL_FRAMING = 1;
  localparam int unsigned FL_PARITY = 0;

  // ==========================================================
  // Reset values.
  localparam logic [12:0] BAUD_RST = 13'h0001;
  localparam logic [6:0] CTRL_RST = 7'h00;
  localparam logic [6:0] CTL3_RST = 7'h00;

  // ==========================================================
  // Sixteen ticks per bit; majority samples at ticks 7, 8 and 9.
  localparam logic [3:0] RT_LAST = 4'hF;
  localparam logic [3:0] RT_SMP_FIRST = 4'h7;
  localparam logic [3:0] RT_SMP_LAST = 4'h9;
  localparam logic [3:0] RT_RESTART = 4'h1;
  localparam logic [3:0] BITS_8 = 4'hA;
  localparam logic [3:0] BITS_9 = 4'hB;

  typedef enum {TX_IDLE, TX_SHIFT} usd_tx_type;
  typedef enum {RX_IDLE, RX_BITS} usd_rx_type;

endpackage : usd_pkg

// ==== hdl/usd_top.sv ====
`timescale 1ns/1ns

// ============================================================
// Transmit buffer with valid/ready on both sides.
module usd_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;

  assign in_ready = cnt_r != (AW+1)'(DEPTH);
  assign out_valid = cnt_r != '0;
  assign out_data = mem[rp_r];

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else if (ce) begin
      if (push) begin
        wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge core_clk) begin
    if (ce && push) begin
      mem[wp_r] <= in_data;
    end
  end
endmodule : usd_fifo

// Behaviour
// - Nine-bit mode: received ninth bit reads at control three bit 7.
// - Data write sends transmit ninth bit (bit 6) with the byte.
// - Single-wire mode: bit 5 set drives pin, clear makes it input.
// - Bit 4 inverts whole transmit output, idle level included.
// - Bit 3 gates overrun flag onto the error request.
// - Bit 2 gates noise flag onto the error request.
// - Bit 1 gates framing flag onto the error request.
// - Bit 0 gates parity flag onto the error request.
// - Data address reads receive buffer, writes transmit buffer.
// - Data register reads take part in flag clearing; data writes do not.
// - Baud generator runs from bus clock, shared by both directions.
// - Full-duplex asynchronous NRZ transfer.
// - Receiver realigns bit timing at falling edges in a frame, except those at sample ticks 7 to 9.
// - Error flag clears after status read with it set, then data read.
module usd_top
  import usd_pkg::*;
#(
  parameter int BAUD_W = 13,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_pin,
  input wire logic tx_pin_in,
  output logic tx_pin_out,
  output logic tx_pin_oe,
  output logic err_irq
);
  // ==========================================================
  // Register state.
  logic [BAUD_W-1:0] baud_r;
  logic [6:0] ctrl_r;
  logic [6:0] ctl3_r;
  logic [8:0] rx_buf_r;
  logic [4:0] flags_r;
  logic [4:0] armed_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic tx_out_r;
  logic tx_oe_r;
  logic irq_r;

  // ==========================================================
  // APB decode.
  wire sel_baud = paddr == ADDR_BAUD;
  wire sel_ctrl = paddr == ADDR_CTRL;
  wire sel_stat = paddr == ADDR_STAT;
  wire sel_ctl3 = paddr == ADDR_CTL3;
  wire sel_data = paddr == ADDR_DATA;
  wire hit = sel_baud | sel_ctrl | sel_stat | sel_ctl3 | sel_data;
  wire access = psel & penable;
  wire done = access & pready_r;
  wire wr_done = done & pwrite;
  wire rd_done = done & ~pwrite;
  wire fifo_in_ready;
  wire data_push = wr_done & sel_data;
  wire can_answer = ~(pwrite & sel_data) | fifo_in_ready;
  wire pready_nxt = access & ~pready_r & can_answer;
  wire stat_rd = rd_done & sel_stat;
  wire data_rd = rd_done & sel_data;

  wire rx_en = ctrl_r[CT_RX_EN];
  wire tx_en = ctrl_r[CT_TX_EN];
  wire nine = ctrl_r[CT_NINE_BIT];
  wire par_en = ctrl_r[CT_PAR_EN];
  wire par_odd = ctrl_r[CT_PAR_ODD];
  wire single_wire = ctrl_r[CT_LOOP_SEL] & ctrl_r[CT_RX_SRC_SEL];

  // ==========================================================
  // Transmit buffer; a full buffer stalls the APB write.
  wire fifo_out_valid;
  wire fifo_out_ready;
  wire [8:0] fifo_out_data;

  usd_fifo #(
    .WIDTH(9),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .in_valid(data_push),
    .in_ready(fifo_in_ready),
    .in_data({ctl3_r[C3_TX_NINTH], pwdata[7:0]}),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // ==========================================================
  // Baud generator on the bus clock, one tick per sixteenth bit.
  logic [BAUD_W-1:0] baud_cnt_r;
  wire tick = (baud_r != '0) && (baud_cnt_r == baud_r - 1'b1);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      baud_cnt_r <= '0;
    end else if (ce) begin
      baud_cnt_r <= tick ? '0 : baud_cnt_r + 1'b1;
    end
  end

  // ==========================================================
  // Transmitter.
  usd_tx_type tx_st_r;
  logic [10:0] tx_sh_r;
  logic [3:0] tx_bits_r;
  logic [3:0] tx_rt_r;
  wire [7:0] td = fifo_out_data[7:0];
  wire tx_par = nine ? (^td ^ par_odd) : (^td[6:0] ^ par_odd);
  wire tx_b8 = (nine & par_en) ? tx_par : fifo_out_data[8];
  wire tx_b7 = (~nine & par_en) ? tx_par : td[7];
  wire [10:0] tx_frame = nine ? {1'b1, tx_b8, tx_b7, td[6:0], 1'b0}
                              : {2'b11, tx_b7, td[6:0], 1'b0};
  wire tx_load = fifo_out_valid & fifo_out_ready;
  wire tx_bit_end = (tx_st_r == TX_SHIFT) & tick & (tx_rt_r == RT_LAST);
  wire tx_line = (tx_st_r == TX_SHIFT) ? tx_sh_r[0] : 1'b1;
  assign fifo_out_ready = (tx_st_r == TX_IDLE) & tx_en;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tx_st_r <= TX_IDLE;
      tx_sh_r <= '1;
      tx_bits_r <= '0;
      tx_rt_r <= '0;
    end else if (ce) begin
      if (tx_load) begin
        tx_st_r <= TX_SHIFT;
        tx_sh_r <= tx_frame;
        tx_bits_r <= nine ? BITS_9 : BITS_8;
        tx_rt_r <= '0;
      end else if (tx_st_r == TX_SHIFT && tick) begin
        tx_rt_r <= tx_rt_r + 1'b1;
        if (tx_bit_end) begin
          tx_sh_r <= {1'b1, tx_sh_r[10:1]};
          tx_bits_r <= tx_bits_r - 1'b1;
          if (tx_bits_r == 4'h1) begin
            tx_st_r <= TX_IDLE;
          end
        end
      end
    end
  end

  // ==========================================================
  // Pin synchronisers: three stages, accept when stages 2 and 3 agree.
  logic [1:0] s1_r;
  logic [1:0] s2_r;
  logic [1:0] s3_r;
  logic [1:0] filt_r;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s1_r <= '1;
      s2_r <= '1;
      s3_r <= '1;
      filt_r <= '1;
    end else if (ce) begin
      s1_r <= {tx_pin_in, rx_pin};
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int i = 0; i < 2; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          filt_r[i] <= s3_r[i];
        end
      end
    end
  end

  wire rx_src = ctrl_r[CT_LOOP_SEL] ?
                (ctrl_r[CT_RX_SRC_SEL] ? filt_r[1] : tx_line) : filt_r[0];

  // ==========================================================
  // Receiver with majority sampling and falling-edge realignment.
  usd_rx_type rx_st_r;
  logic rx_prev_r;
  logic [3:0] rx_rt_r;
  logic [3:0] rx_idx_r;
  logic [2:0] smp_r;
  logic [8:0] rx_sh_r;
  logic rx_noise_r;
  wire rx_bits = rx_st_r == RX_BITS;
  wire fall = tick & rx_prev_r & ~rx_src;
  wire late_edge = rx_bits & fall & (rx_rt_r > RT_SMP_LAST);
  wire early_edge = rx_bits & fall & (rx_rt_r < RT_SMP_FIRST);
  wire rx_bit_end = rx_bits & tick & ((rx_rt_r == RT_LAST) | late_edge);
  wire in_smp = (rx_rt_r >= RT_SMP_FIRST) & (rx_rt_r <= RT_SMP_LAST);
  wire maj = (smp_r[0] & smp_r[1]) | (smp_r[0] & smp_r[2])
           | (smp_r[1] & smp_r[2]);
  wire noisy = (smp_r != 3'b000) & (smp_r != 3'b111);
  wire [3:0] rx_last = (nine ? BITS_9 : BITS_8) - 4'h1;
  wire rx_stop = rx_bit_end & (rx_idx_r == rx_last);
  wire [8:0] rx_data = nine ? rx_sh_r : {1'b0, rx_sh_r[8:1]};
  wire fe_ev = ~maj;
  wire pf_ev = par_en & ((^rx_data) != par_odd);
  wire nf_ev = rx_noise_r | noisy;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rx_st_r <= RX_IDLE;
      rx_prev_r <= 1'b1;
      rx_rt_r <= '0;
      rx_idx_r <= '0;
      smp_r <= '0;
      rx_sh_r <= '0;
      rx_noise_r <= 1'b0;
    end else if (ce) begin
      if (tick) begin
        rx_prev_r <= rx_src;
      end
      if (rx_st_r == RX_IDLE) begin
        if (rx_en && fall) begin
          rx_st_r <= RX_BITS;
          rx_rt_r <= RT_RESTART;
          rx_idx_r <= '0;
          rx_noise_r <= 1'b0;
        end
      end else if (tick) begin
        if (in_smp) begin
          smp_r <= {smp_r[1:0], rx_src};
        end
        if (rx_bit_end) begin
          rx_rt_r <= fall ? RT_RESTART : '0;
          rx_idx_r <= rx_idx_r + 1'b1;
          rx_noise_r <= nf_ev;
          if (rx_idx_r != '0 && !rx_stop) begin
            rx_sh_r <= {maj, rx_sh_r[8:1]};
          end
          if ((rx_idx_r == '0 && maj) || rx_stop || !rx_en) begin
            rx_st_r <= RX_IDLE;
          end
        end else begin
          rx_rt_r <= early_edge ? RT_RESTART : rx_rt_r + 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Status flags: hardware set wins over the clearing sequence.
  wire [4:0] clr = data_rd ? armed_r : 5'h00;
  wire rx_full_eff = flags_r[FL_RX_FULL] & ~clr[FL_RX_FULL];
  wire rx_take = rx_stop & ~rx_full_eff;
  wire rx_lost = rx_stop & rx_full_eff;
  wire [4:0] set_ev = rx_take ? {1'b1, 1'b0, nf_ev, fe_ev, pf_ev}
                    : (rx_lost ? 5'h08 : 5'h00);
  wire [4:0] flags_nxt = (flags_r & ~clr) | set_ev;
  wire [3:0] err_en = ctl3_r[C3_OVR_IE:C3_PAR_IE];
  wire irq_nxt =
      |(flags_r[FL_OVERRUN:FL_PARITY] & err_en);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      flags_r <= '0;
      armed_r <= '0;
      rx_buf_r <= '0;
      irq_r <= 1'b0;
    end else if (ce) begin
      flags_r <= flags_nxt;
      irq_r <= irq_nxt;
      if (stat_rd) begin
        armed_r <= flags_r;
      end else if (data_rd) begin
        armed_r <= '0;
      end
      if (rx_take) begin
        rx_buf_r <= rx_data;
      end
    end
  end

  // ==========================================================
  // Register writes and read data.
  wire tx_done_st = (tx_st_r == TX_IDLE) & ~fifo_out_valid;
  wire [7:0] stat_val = {fifo_in_ready, tx_done_st, 1'b0, flags_r};
  wire [7:0] ctl3_val = {rx_buf_r[8], ctl3_r};
  wire [31:0] rdata_mux =
      sel_baud ? {{(32-BAUD_W){1'b0}}, baud_r}
    : sel_ctrl ? {25'h000_0000, ctrl_r}
    : sel_stat ? {24'h00_0000, stat_val}
    : sel_ctl3 ? {24'h00_0000, ctl3_val}
    : sel_data ? {24'h00_0000, rx_buf_r[7:0]}
    : 32'h0000_0000;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      baud_r <= BAUD_RST[BAUD_W-1:0];
      ctrl_r <= CTRL_RST;
      ctl3_r <= CTL3_RST;
      pready_r <= 1'b0;
      prdata_r <= '0;
      pslverr_r <= 1'b0;
    end else if (ce) begin
      pready_r <= pready_nxt;
      pslverr_r <= pready_nxt & ~hit;
      if (pready_nxt) begin
        prdata_r <= pwrite ? 32'h0000_0000 : rdata_mux;
      end
      if (wr_done && sel_baud) begin
        baud_r <= pwdata[BAUD_W-1:0];
      end
      if (wr_done && sel_ctrl) begin
        ctrl_r <= pwdata[6:0];
      end
      if (wr_done && sel_ctl3) begin
        ctl3_r <= pwdata[6:0];
      end
    end
  end

  // ==========================================================
  // Pin and request outputs.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tx_out_r <= 1'b1;
      tx_oe_r <= 1'b0;
    end else if (ce) begin
      tx_out_r <= tx_line ^ ctl3_r[C3_TX_INV];
      tx_oe_r <= single_wire ? ctl3_r[C3_PIN_DIR] : tx_en;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign tx_pin_out = tx_out_r;
  assign tx_pin_oe = tx_oe_r;
  assign err_irq = irq_r;
endmodule : usd_top

// ==== tb/tb_top.sv ====
`timescale 1ns/1ns
module tb_top
  import usd_pkg::*;
;
  logic core_clk, sys_rst, ce, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, b;
  logic [31:0] pwdata, prdata;
  logic rx_pin, tx_pin_in, tx_pin_out, tx_pin_oe, err_irq;
  logic s_go, s_nine, s_stop, s_inv, g_v;
  logic [8:0] s_dat, g_dat;
  logic [15:0] seed;
  logic [33:0] nt;
  logic [33:0] aq[$];
  logic [8:0] sq[$];
  int failures, n_compared;
  assign tx_pin_in = tx_pin_oe ? tx_pin_out : 1'b1;
  usd_top #(.BAUD_W(13), .FIFO_DEPTH(16)) i_usd_top (
    .core_clk(core_clk), .sys_rst(sys_rst), .ce(ce), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_pin(rx_pin),
    .tx_pin_in(tx_pin_in), .tx_pin_out(tx_pin_out),
    .tx_pin_oe(tx_pin_oe), .err_irq(err_irq));
  usd_peer #(.BIT_CLKS(32)) i_usd_peer (.core_clk(core_clk), .inv(s_inv),
    .nine(s_nine), .send(s_go), .send_data(s_dat), .stop(s_stop),
    .tx_line(tx_pin_out), .rx_pin(rx_pin), .got_valid(g_v),
    .got_data(g_dat));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  // Note bit 33 skips the data compare, bit 32 expects pslverr.
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d, logic [33:0] n);
    aq.push_back(n);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, '0, {2'b00, e});
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, '0);
  endtask : wr
  task automatic send(input logic [8:0] d, input logic st);
    s_dat <= d;
    s_stop <= st;
    s_go <= 1'b1;
    @(posedge core_clk);
    s_go <= 1'b0;
    repeat (400) @(posedge core_clk);
  endtask : send
  task automatic done(input string t);
    $display("test %s done", t);
  endtask : done
  task automatic stop_test;
    $display("%0d compared, %0d failures", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  // ==========================================================
  // Result monitor.
  always @(posedge core_clk) begin
    if (psel && penable && pready === 1'b1) begin
      nt = aq.pop_front();
      chk(32'(pslverr), 32'(nt[32]));
      if (!nt[33]) chk(prdata, nt[31:0]);
    end
    if (g_v === 1'b1) chk(32'(g_dat), 32'(sq.pop_front()));
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    $display("BAD %0t watchdog expired", $time);
    stop_test();
  end
  // ==========================================================
  // Stimulus.
  initial begin
    {ce, sys_rst, s_inv, s_stop} = 4'hD;
    {psel, penable, pwrite, paddr, pwdata, s_go, s_nine, s_dat} = '0;
    seed = 16'h3526;
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    s_inv <= 1'b0;
    rd(ADDR_CTL3, 32'h0000_0000);
    rd(ADDR_BAUD, 32'h0000_0001);
    rd(ADDR_STAT, 32'h0000_00C0);
    apb(1'b0, 8'h14, '0, {2'b01, 32'h0000_0000});
    apb(1'b1, 8'h14, 32'h0000_00FF, {2'b01, 32'h0000_0000});
    wr(ADDR_BAUD, 32'h0000_0002);
    wr(ADDR_CTL3, 32'h0000_0010);
    @(posedge core_clk);
    chk(32'(tx_pin_out), 32'h0000_0000);
    wr(ADDR_CTL3, 32'h0000_0000);
    @(posedge core_clk);
    chk(32'(tx_pin_out), 32'h0000_0001);
    wr(ADDR_CTRL, 32'h0000_0060);
    wr(ADDR_CTL3, 32'h0000_0020);
    @(posedge core_clk);
    chk(32'(tx_pin_oe), 32'h0000_0001);
    wr(ADDR_CTL3, 32'h0000_0000);
    @(posedge core_clk);
    chk(32'(tx_pin_oe), 32'h0000_0000);
    done("registers");
    s_nine <= 1'b1;
    wr(ADDR_CTRL, 32'h0000_0006);
    wr(ADDR_CTL3, 32'h0000_0050);
    s_inv <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (i == 2) wr(ADDR_CTL3, 32'h0000_0010);
      seed = lfsr(seed);
      sq.push_back({i < 2, seed[7:0]});
      wr(ADDR_DATA, {24'h00_0000, seed[7:0]});
    end
    for (int k = 0; k < 3000 && sq.size() > 0; k++) @(posedge core_clk);
    chk(sq.size(), 0);
    wr(ADDR_CTL3, 32'h0000_0000);
    s_inv <= 1'b0;
    done("transmit");
    wr(ADDR_CTRL, 32'h0000_0007);
    for (int e = 0; e < 3; e++) begin
      wr(ADDR_CTL3, e == 1 ? 32'h0000_0008 : 32'h0000_0000);
      seed = lfsr(seed);
      b = seed[7:0];
      send({e == 0, b}, e != 2);
      if (e == 1) send({1'b0, ~b}, 1'b1);
      chk(32'(err_irq), 32'(e == 1));
      if (e == 2) wr(ADDR_CTL3, 32'h0000_0002);
      repeat (3) @(posedge core_clk);
      chk(32'(err_irq), 32'(e != 0));
      rd(ADDR_STAT, e == 0 ? 32'h0000_00D0 : e == 1 ? 32'h0000_00D8
        : 32'h0000_00D2);
      rd(ADDR_CTL3, {24'h00_0000, e == 0, 7'h00} | (e == 1 ? 8 : 0)
        | (e == 2 ? 2 : 0));
      rd(ADDR_DATA, {24'h00_0000, b});
      repeat (3) @(posedge core_clk);
      chk(32'(err_irq), 32'h0000_0000);
    end
    done("receive");
    s_nine <= 1'b0;
    wr(ADDR_CTRL, 32'h0000_000B);
    wr(ADDR_CTL3, 32'h0000_0001);
    send({1'b0, ~(^b[6:0]), b[6:0]}, 1'b1);
    chk(32'(err_irq), 32'h0000_0001);
    rd(ADDR_STAT, 32'h0000_00D1);
    apb(1'b0, ADDR_DATA, '0, {2'b10, 32'h0000_0000});
    repeat (3) @(posedge core_clk);
    chk(32'(err_irq), 32'h0000_0000);
    done("parity");
    stop_test();
  end
endmodule : tb_top

// ==== tb/usd_peer.sv ====
`timescale 1ns/1ns
module usd_peer #(
  parameter int BIT_CLKS = 32
) (
  input wire logic core_clk,
  input wire logic inv,
  input wire logic nine,
  input wire logic send,
  input wire logic [8:0] send_data,
  input wire logic stop,
  input wire logic tx_line,
  output logic rx_pin,
  output logic got_valid,
  output logic [8:0] got_data
);
  logic line;
  assign line = tx_line ^ inv;
  // Sender keeps the exact bit rate, LSB first; line idles high.
  initial begin
    logic [10:0] fr;
    rx_pin = 1'b1;
    forever begin
      @(posedge core_clk);
      if (send) begin
        fr = nine ? {stop, send_data, 1'b0}
                  : {1'b1, stop, send_data[7:0], 1'b0};
        for (int i = 0; i < (nine ? 11 : 10); i++) begin
          rx_pin <= fr[i];
          repeat (BIT_CLKS) @(posedge core_clk);
        end
        rx_pin <= 1'b1;
      end
    end
  end
  // Receiver samples mid-bit and drops false starts.
  initial begin
    got_valid = 1'b0;
    got_data = 9'h000;
    forever begin
      @(posedge core_clk);
      got_valid <= 1'b0;
      if (line == 1'b0) begin
        repeat (BIT_CLKS / 2) @(posedge core_clk);
        if (line == 1'b0) begin
          got_data <= 9'h000;
          for (int i = 0; i < (nine ? 9 : 8); i++) begin
            repeat (BIT_CLKS) @(posedge core_clk);
            got_data[i] <= line;
          end
          repeat (BIT_CLKS) @(posedge core_clk);
          got_valid <= 1'b1;
        end
      end
    end
  end
endmodule : usd_peer

// ==== tb/usd_top_sva.sv ====
`timescale 1ns/1ns
module usd_top_sva
  import usd_pkg::*;
#(
  parameter int BAUD_W = 13,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic tx_pin_out,
  input wire logic tx_pin_oe,
  input wire logic err_irq
);
  // ==========================================================
  // Mirrors of the control bits and quiet-time counters.
  logic acc, w3, wc, wd, rd;
  logic [6:0] c3_r, ct_r;
  logic sent_r;
  logic [3:0] q_r, k_r;
  assign acc = ce && psel && penable && pready;
  assign w3 = acc && pwrite && paddr == ADDR_CTL3;
  assign wc = acc && pwrite && paddr == ADDR_CTRL;
  assign wd = acc && pwrite && paddr == ADDR_DATA;
  assign rd = acc && !pwrite && paddr == ADDR_DATA;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      c3_r <= 7'h00;
      ct_r <= 7'h00;
      sent_r <= 1'b0;
    end else begin
      if (w3) c3_r <= pwdata[6:0];
      if (wc) ct_r <= pwdata[6:0];
      if (wd) sent_r <= 1'b1;
    end
  end
  always_ff @(posedge core_clk) begin
    if (sys_rst || w3 || wc) q_r <= 4'h0;
    else if (q_r != 4'hF) q_r <= q_r + 4'h1;
  end
  always_ff @(posedge core_clk) begin
    if (sys_rst || w3 || rd) k_r <= 4'h0;
    else if (k_r != 4'hF) k_r <= k_r + 4'h1;
  end
  // ==========================================================
  // Properties.
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("pready held");
  property p_err; pslverr |-> pready && psel && penable; endproperty
  a_err: assert property (p_err) else $error("stray slverr");
  property p_zero; pready && pslverr && !pwrite |-> prdata == '0;
  endproperty
  a_zero: assert property (p_zero) else $error("bad read data");
  property p_dir;
    q_r > 2 && ct_r[CT_LOOP_SEL] && ct_r[CT_RX_SRC_SEL]
      |-> tx_pin_oe == c3_r[C3_PIN_DIR];
  endproperty
  a_dir: assert property (p_dir) else $error("pin direction");
  property p_idle;
    q_r > 2 && !sent_r |-> tx_pin_out == !c3_r[C3_TX_INV];
  endproperty
  a_idle: assert property (p_idle) else $error("idle level");
  property p_on;
    acc && !pwrite && paddr == ADDR_STAT && q_r > 2 &&
      (prdata[3:0] & c3_r[3:0]) != 4'h0 |-> ##[0:2] err_irq;
  endproperty
  a_on: assert property (p_on) else $error("irq missing");
  property p_off; q_r > 2 && c3_r[3:0] == 4'h0 |-> !err_irq; endproperty
  a_off: assert property (p_off) else $error("irq unmasked");
  property p_hold; $fell(err_irq) |-> k_r < 4'h4; endproperty
  a_hold: assert property (p_hold) else $error("irq fell early");
  c_on: cover property (err_irq);
  c_wire: cover property (tx_pin_oe && ct_r[CT_LOOP_SEL]);
  c_bad: cover property (pslverr);
endmodule : usd_top_sva

bind usd_top usd_top_sva #(.BAUD_W(BAUD_W), .FIFO_DEPTH(FIFO_DEPTH))
  i_usd_top_sva (.core_clk(core_clk), .sys_rst(sys_rst), .ce(ce),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .tx_pin_out(tx_pin_out), .tx_pin_oe(tx_pin_oe), .err_irq(err_irq));
